// ==== shared/erdw_defs.svh ====
// Register offsets, field positions, reset values and descriptor layout
// for the receive descriptor writer and wake pattern detector.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ERDW_DEFS_SVH
`define ERDW_DEFS_SVH

`define ERDW_REG_CTRL       8'h00
`define ERDW_REG_STA_LO     8'h04
`define ERDW_REG_STA_HI     8'h08
`define ERDW_REG_RING_BASE  8'h0c
`define ERDW_REG_STATUS     8'h10
`define ERDW_REG_COUNTS     8'h14
`define ERDW_REG_CUR_DESC   8'h18
`define ERDW_REG_BUF_PTR    8'h1c

`define ERDW_CTRL_SWAP      0
`define ERDW_CTRL_WAKE      1
`define ERDW_CTRL_EXT       2
`define ERDW_CTRL_RESET     3'h0
`define ERDW_STAT_WAKE      0
`define ERDW_STAT_BUSY      1

`define ERDW_OFS_STATUS     32'h0000_0000
`define ERDW_OFS_PTR        32'h0000_0004
`define ERDW_OFS_EXT0       32'h0000_0008
`define ERDW_OFS_EXT1       32'h0000_000c
`define ERDW_SIZE_LEGACY    32'h0000_0008
`define ERDW_SIZE_EXT       32'h0000_0020

`define ERDW_BD_EMPTY       15
`define ERDW_BD_LAST        11
`define ERDW_BD_BCAST       7
`define ERDW_BD_MCAST       6
`define ERDW_BD_CRC         2
`define ERDW_BD_VLAN        2
`define ERDW_BD_IPV6        1

`define ERDW_ETYPE_VLAN     16'h8100
`define ERDW_ETYPE_IPV4     16'h0800
`define ERDW_ETYPE_IPV6     16'h86dd
`define ERDW_HDR_PLAIN      5'h0e
`define ERDW_HDR_TAGGED     5'h12
`define ERDW_POS_TYPE_HI    16'h000c
`define ERDW_POS_TYPE_LO    16'h000d
`define ERDW_POS_TCI        16'h000e
`define ERDW_POS_ITYPE_HI   16'h0010
`define ERDW_POS_ITYPE_LO   16'h0011
`define ERDW_POS_PROTO      16'h0017
`define ERDW_POS_PROTO_TAG  16'h001b
`define ERDW_POS_DA_LAST    16'h0005

`define ERDW_WAKE_SYNC      3'h6
`define ERDW_WAKE_LAST_COPY 4'hf
`define ERDW_WAKE_LAST_BYTE 3'h5

`endif

// ==== shared/erdw_pkg.sv ====
// Types shared by the descriptor writer and the wake detector.
// Assumes erdw_defs.svh is on the include path.
`include "erdw_defs.svh"

package erdw_pkg;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_RD_STAT = 6'b000010,
    ST_RD_PTR  = 6'b000100,
    ST_WR_STAT = 6'b001000,
    ST_WR_EXT0 = 6'b010000,
    ST_WR_EXT1 = 6'b100000
  } erdw_state_e;

  typedef logic [31:0] erdw_word_t;

endpackage : erdw_pkg

// ==== rtl/erdw_wake_detect.sv ====
// Wake pattern detector: sync run of all-ones bytes then sixteen station addresses.
// Assumes a byte stream on the same clock, one byte per valid cycle, last marks frame end.
`timescale 1ns/1ns
`default_nettype none
`include "erdw_defs.svh"

module erdw_wake_detect
  import erdw_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        enable_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        last_in,
  input  wire logic [47:0] station_in,
  output logic             found_out
);

  logic [2:0] ff_run_reg;
  logic [2:0] sel_reg;
  logic [3:0] copy_reg;
  logic [7:0] expect_byte;
  logic       is_ff;
  logic       armed;
  logic       hit;
  logic       done;

  assign expect_byte = station_in[{sel_reg, 3'b000} +: 8];
  assign is_ff       = (byte_in == 8'hff);
  assign armed       = (ff_run_reg == `ERDW_WAKE_SYNC);
  assign hit         = (byte_in == expect_byte);
  assign done        = hit && (sel_reg == `ERDW_WAKE_LAST_BYTE) && (copy_reg == `ERDW_WAKE_LAST_COPY);

  // Search restarts on any mismatching byte, so the pattern may sit anywhere in the frame
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !enable_in) begin
      ff_run_reg <= 3'h0;
      sel_reg    <= 3'h0;
      copy_reg   <= 4'h0;
    end else if (byte_valid_in) begin
      if (last_in || (armed && done)) begin
        ff_run_reg <= 3'h0;
        sel_reg    <= 3'h0;
        copy_reg   <= 4'h0;
      end else if (!armed) begin
        ff_run_reg <= is_ff ? ff_run_reg + 3'h1 : 3'h0;
      end else if (is_ff && sel_reg == 3'h0 && copy_reg == 4'h0) begin
        ff_run_reg <= ff_run_reg;
      end else if (hit) begin
        if (sel_reg == `ERDW_WAKE_LAST_BYTE) begin
          sel_reg  <= 3'h0;
          copy_reg <= copy_reg + 4'h1;
        end else begin
          sel_reg <= sel_reg + 3'h1;
        end
      end else begin
        // Fewer than sixteen copies falls back to hunting for sync
        ff_run_reg <= is_ff ? 3'h1 : 3'h0;
        sel_reg    <= 3'h0;
        copy_reg   <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      found_out <= 1'b0;
    end else begin
      found_out <= enable_in && byte_valid_in && armed && done;
    end
  end

endmodule : erdw_wake_detect
`default_nettype wire

// ==== rtl/erdw_rx_top.sv ====
// Receive descriptor writer with wake pattern detection and Wishbone registers.
// Assumes rx byte stream on clk_in, a word-wide memory master port with ack,
// and a classic Wishbone master for the control registers.
//
// Functional notes
// - Wake needs six all-ones bytes then sixteen back-to-back station addresses.
// - The wake pattern is searched at any byte position in the frame.
// - Sync followed by only six address copies raises no wake event.
// - Extended descriptors carry the priority code in bits 15..13 of half-word 0xA.
// - Priority is written only in extended format; legacy writes none.
// - Descriptor byte swap is disabled after reset.
// - Swap off: descriptor half-words and pointers use big-endian order.
// - Swap on: each descriptor word is byte-reversed for little-endian software.
// - Swap acts per 32-bit word, so length and status change places.
// - Legacy and extended formats use the same swap behaviour.
// - Buffer address comes from offset 0x4 (high half) and 0x6 (low).
// - Extended half-word 0xC holds header length high, protocol type low.
// - Priority is meaningful only in the descriptor marked last in frame.
// - Priority is copied from the received tag; 7 is highest.
// - A control register bit enables the descriptor byte swap.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "erdw_defs.svh"

module erdw_rx_top
  import erdw_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_last_in,
  input  wire logic        rx_crc_err_in,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [31:0]      mem_adr_out,
  output logic [31:0]      mem_dat_out,
  input  wire logic [31:0] mem_dat_in,
  input  wire logic        mem_ack_in,
  output logic [31:0]      buf_ptr_out,
  output logic             buf_ptr_valid_out,
  output logic             desc_done_out,
  output logic             wake_flag_out
);

  // Byte reversal of a whole word; its own inverse
  function automatic erdw_word_t brev(input erdw_word_t w);
    brev = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : brev

  // Word image of half-words at offsets +0 and +2 in memory order
  function automatic erdw_word_t fmt(input logic [15:0] h0, input logic [15:0] h2, input logic swap);
    fmt = swap ? {h0, h2} : brev({h0, h2});
  endfunction : fmt

  // Register file
  logic [2:0]  ctrl_reg;
  logic [31:0] sta_lo_reg;
  logic [15:0] sta_hi_reg;
  logic [31:0] ring_base_reg;
  logic [31:0] desc_addr_reg;
  logic [15:0] frame_cnt_reg;
  logic [15:0] drop_cnt_reg;
  logic        ack_reg;
  logic [31:0] wmask;
  logic [31:0] rd_next;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  reg_ofs;

  // Frame parser
  logic [15:0] pos_reg;
  logic        bc_reg;
  logic        mc_reg;
  logic        tagged_reg;
  logic [2:0]  pcp_reg;
  logic [15:0] type_reg;
  logic [7:0]  proto_reg;
  logic        tag_now;
  logic        fin_byte;
  logic        wake_hit;

  // Descriptor engine
  erdw_state_e state_reg;
  logic        swap_l_reg;
  logic        ext_l_reg;
  logic [15:0] len_l_reg;
  logic        bc_l_reg;
  logic        mc_l_reg;
  logic        crc_l_reg;
  logic        tag_l_reg;
  logic        ipv6_l_reg;
  logic [2:0]  pcp_l_reg;
  logic [7:0]  proto_l_reg;
  logic [2:0]  keep_bits_reg;
  logic        wrap_reg;
  logic        start;
  logic        ack_now;
  logic        finish;
  logic        not_empty;
  erdw_word_t  rd_word;
  logic [15:0] stat_half;
  logic [15:0] ext_a_half;
  logic [15:0] ext_c_half;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[8*lane +: 8] = {8{wb_sel_in[lane]}};
    end
  endgenerate

  assign reg_ofs = {wb_adr_in[7:2], 2'b00};
  assign bus_rd  = wb_cyc_in && wb_stb_in && !ack_reg;
  // Writes land on the edge where the master sees ack
  assign bus_wr  = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (reg_ofs)
      `ERDW_REG_CTRL:      rd_next = {29'h0, ctrl_reg};
      `ERDW_REG_STA_LO:    rd_next = sta_lo_reg;
      `ERDW_REG_STA_HI:    rd_next = {16'h0, sta_hi_reg};
      `ERDW_REG_RING_BASE: rd_next = ring_base_reg;
      `ERDW_REG_STATUS:    rd_next = {30'h0, state_reg != ST_IDLE, wake_flag_out};
      `ERDW_REG_COUNTS:    rd_next = {drop_cnt_reg, frame_cnt_reg};
      `ERDW_REG_CUR_DESC:  rd_next = desc_addr_reg;
      `ERDW_REG_BUF_PTR:   rd_next = buf_ptr_out;
      default:             rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg    <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      ack_reg    <= bus_rd;
      wb_ack_out <= bus_rd;
      if (bus_rd) begin
        wb_dat_out <= rd_next;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_reg      <= `ERDW_CTRL_RESET;
      sta_lo_reg    <= 32'h0000_0000;
      sta_hi_reg    <= 16'h0000;
      ring_base_reg <= 32'h0000_0000;
    end else if (bus_wr) begin
      unique case (reg_ofs)
        `ERDW_REG_CTRL:      ctrl_reg <= (ctrl_reg & ~wmask[2:0]) | (wb_dat_in[2:0] & wmask[2:0]);
        `ERDW_REG_STA_LO:    sta_lo_reg <= (sta_lo_reg & ~wmask) | (wb_dat_in & wmask);
        `ERDW_REG_STA_HI:    sta_hi_reg <= (sta_hi_reg & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
        `ERDW_REG_RING_BASE: ring_base_reg <= (ring_base_reg & ~wmask) | (wb_dat_in & wmask);
        default:             ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Sticky wake flag, write one to clear; a new hit beats the clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wake_flag_out <= 1'b0;
    end else if (wake_hit) begin
      wake_flag_out <= 1'b1;
    end else if (bus_wr && reg_ofs == `ERDW_REG_STATUS && wb_sel_in[0] && wb_dat_in[`ERDW_STAT_WAKE]) begin
      wake_flag_out <= 1'b0;
    end
  end

  erdw_wake_detect u_wake (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .enable_in     (ctrl_reg[`ERDW_CTRL_WAKE]),
    .byte_valid_in (rx_valid_in),
    .byte_in       (rx_data_in),
    .last_in       (rx_last_in),
    .station_in    ({sta_hi_reg, sta_lo_reg}),
    .found_out     (wake_hit)
  );

  assign fin_byte = rx_valid_in && rx_last_in;
  assign tag_now  = ({type_reg[15:8], rx_data_in} == `ERDW_ETYPE_VLAN);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pos_reg    <= 16'h0000;
      bc_reg     <= 1'b0;
      mc_reg     <= 1'b0;
      tagged_reg <= 1'b0;
      pcp_reg    <= 3'h0;
      type_reg   <= 16'h0000;
      proto_reg  <= 8'h00;
    end else if (rx_valid_in) begin
      pos_reg <= rx_last_in ? 16'h0000 : pos_reg + 16'h0001;
      if (pos_reg == 16'h0000) begin
        bc_reg     <= (rx_data_in == 8'hff);
        mc_reg     <= rx_data_in[0];
        tagged_reg <= 1'b0;
        pcp_reg    <= 3'h0;
        proto_reg  <= 8'h00;
      end else if (pos_reg <= `ERDW_POS_DA_LAST) begin
        bc_reg <= bc_reg && (rx_data_in == 8'hff);
      end
      if (pos_reg == `ERDW_POS_TYPE_HI) begin
        type_reg[15:8] <= rx_data_in;
      end
      if (pos_reg == `ERDW_POS_TYPE_LO) begin
        type_reg[7:0] <= rx_data_in;
        tagged_reg    <= tag_now;
      end
      if (tagged_reg && pos_reg == `ERDW_POS_TCI) begin
        pcp_reg <= rx_data_in[7:5];
      end
      if (tagged_reg && pos_reg == `ERDW_POS_ITYPE_HI) begin
        type_reg[15:8] <= rx_data_in;
      end
      if (tagged_reg && pos_reg == `ERDW_POS_ITYPE_LO) begin
        type_reg[7:0] <= rx_data_in;
      end
      if (type_reg == `ERDW_ETYPE_IPV4 &&
          pos_reg == (tagged_reg ? `ERDW_POS_PROTO_TAG : `ERDW_POS_PROTO)) begin
        proto_reg <= rx_data_in;
      end
    end
  end

  // Frame summary is latched only when the engine is free
  assign start = fin_byte && (state_reg == ST_IDLE);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      swap_l_reg  <= 1'b0;
      ext_l_reg   <= 1'b0;
      len_l_reg   <= 16'h0000;
      bc_l_reg    <= 1'b0;
      mc_l_reg    <= 1'b0;
      crc_l_reg   <= 1'b0;
      tag_l_reg   <= 1'b0;
      ipv6_l_reg  <= 1'b0;
      pcp_l_reg   <= 3'h0;
      proto_l_reg <= 8'h00;
    end else if (start) begin
      swap_l_reg  <= ctrl_reg[`ERDW_CTRL_SWAP];
      ext_l_reg   <= ctrl_reg[`ERDW_CTRL_EXT];
      len_l_reg   <= pos_reg + 16'h0001;
      bc_l_reg    <= bc_reg;
      mc_l_reg    <= mc_reg && !bc_reg;
      crc_l_reg   <= rx_crc_err_in;
      tag_l_reg   <= tagged_reg;
      ipv6_l_reg  <= (type_reg == `ERDW_ETYPE_IPV6);
      pcp_l_reg   <= pcp_reg;
      proto_l_reg <= proto_reg;
    end
  end

  assign ack_now   = mem_req_out && mem_ack_in;
  assign rd_word   = swap_l_reg ? mem_dat_in : brev(mem_dat_in);
  assign not_empty = !rd_word[16 + `ERDW_BD_EMPTY];
  assign finish    = ack_now && ((state_reg == ST_WR_STAT && !ext_l_reg) || state_reg == ST_WR_EXT1);

  // One descriptor per frame, so last-in-frame is always set with the priority
  always_comb begin
    stat_half                = {1'b0, keep_bits_reg, 12'h000};
    stat_half[`ERDW_BD_LAST] = 1'b1;
    stat_half[`ERDW_BD_BCAST] = bc_l_reg;
    stat_half[`ERDW_BD_MCAST] = mc_l_reg;
    stat_half[`ERDW_BD_CRC]  = crc_l_reg;
    ext_a_half               = {pcp_l_reg, 13'h0000};
    ext_a_half[`ERDW_BD_VLAN] = tag_l_reg;
    ext_a_half[`ERDW_BD_IPV6] = ipv6_l_reg;
    ext_c_half               = {tag_l_reg ? `ERDW_HDR_TAGGED : `ERDW_HDR_PLAIN, 3'h0, proto_l_reg};
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg         <= ST_IDLE;
      mem_req_out       <= 1'b0;
      mem_we_out        <= 1'b0;
      mem_adr_out       <= 32'h0000_0000;
      mem_dat_out       <= 32'h0000_0000;
      keep_bits_reg     <= 3'h0;
      wrap_reg          <= 1'b0;
      buf_ptr_out       <= 32'h0000_0000;
      buf_ptr_valid_out <= 1'b0;
    end else begin
      buf_ptr_valid_out <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_RD_STAT;
          end
        end
        ST_RD_STAT: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_we_out  <= 1'b0;
            mem_adr_out <= desc_addr_reg + `ERDW_OFS_STATUS;
          end else if (ack_now) begin
            mem_req_out   <= 1'b0;
            keep_bits_reg <= rd_word[30:28];
            wrap_reg      <= rd_word[29];
            // A descriptor still owned by software drops the frame
            state_reg     <= not_empty ? ST_IDLE : ST_RD_PTR;
          end
        end
        ST_RD_PTR: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_adr_out <= desc_addr_reg + `ERDW_OFS_PTR;
          end else if (ack_now) begin
            mem_req_out       <= 1'b0;
            buf_ptr_out       <= rd_word;
            buf_ptr_valid_out <= 1'b1;
            state_reg         <= ST_WR_STAT;
          end
        end
        ST_WR_STAT: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_we_out  <= 1'b1;
            mem_adr_out <= desc_addr_reg + `ERDW_OFS_STATUS;
            mem_dat_out <= fmt(stat_half, len_l_reg, swap_l_reg);
          end else if (ack_now) begin
            mem_req_out <= 1'b0;
            state_reg   <= ext_l_reg ? ST_WR_EXT0 : ST_IDLE;
          end
        end
        ST_WR_EXT0: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_adr_out <= desc_addr_reg + `ERDW_OFS_EXT0;
            mem_dat_out <= fmt(16'h0000, ext_a_half, swap_l_reg);
          end else if (ack_now) begin
            mem_req_out <= 1'b0;
            state_reg   <= ST_WR_EXT1;
          end
        end
        ST_WR_EXT1: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_adr_out <= desc_addr_reg + `ERDW_OFS_EXT1;
            mem_dat_out <= fmt(ext_c_half, 16'h0000, swap_l_reg);
          end else if (ack_now) begin
            mem_req_out <= 1'b0;
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          state_reg   <= ST_IDLE;
          mem_req_out <= 1'b0;
        end
      endcase
    end
  end

  // Software write of the ring base takes priority over the hardware advance
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      desc_addr_reg <= 32'h0000_0000;
    end else if (bus_wr && reg_ofs == `ERDW_REG_RING_BASE) begin
      desc_addr_reg <= (ring_base_reg & ~wmask) | (wb_dat_in & wmask);
    end else if (finish) begin
      desc_addr_reg <= wrap_reg ? ring_base_reg
                     : desc_addr_reg + (ext_l_reg ? `ERDW_SIZE_EXT : `ERDW_SIZE_LEGACY);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      frame_cnt_reg <= 16'h0000;
      drop_cnt_reg  <= 16'h0000;
      desc_done_out <= 1'b0;
    end else begin
      desc_done_out <= finish;
      if (finish) begin
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
      if ((fin_byte && state_reg != ST_IDLE) || (ack_now && state_reg == ST_RD_STAT && not_empty)) begin
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
    end
  end

endmodule : erdw_rx_top
`default_nettype wire

// ==== bench/erdw_rx_properties.sv ====
// Port checker for the rx descriptor writer and wake detector.
// Assumes a single clock domain and binding onto erdw_rx_top.
`timescale 1ns/1ns
`default_nettype none

module erdw_rx_properties (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        rx_valid_in,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [31:0] mem_adr_out,
  input wire logic        mem_ack_in,
  input wire logic [31:0] buf_ptr_out,
  input wire logic        buf_ptr_valid_out,
  input wire logic        desc_done_out,
  input wire logic        wake_flag_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_ack_one_pulse: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not a single pulse one cycle after request");
  a_req_held: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_adr_out) && $stable(mem_we_out))
    else $error("memory request changed before ack");
  a_req_release: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
    else $error("memory request not dropped after ack");
  a_word_aligned: assert property (mem_req_out |-> mem_adr_out[1:0] == 2'b00)
    else $error("memory access not word aligned");
  a_ptr_from_desc: assert property (buf_ptr_valid_out |-> $past(mem_ack_in) && !$past(mem_we_out) && $past(mem_adr_out[2:0]) == 3'h4)
    else $error("buffer pointer not taken from descriptor word four");
  a_ptr_steady: assert property (!buf_ptr_valid_out |-> $stable(buf_ptr_out))
    else $error("buffer pointer moved without valid");
  a_done_after_wr: assert property (desc_done_out |-> $past(mem_ack_in) && $past(mem_we_out))
    else $error("descriptor done without a finished write");
  a_wake_cause: assert property ($rose(wake_flag_out) |-> $past(rx_valid_in, 2) || $past(rx_valid_in, 3))
    else $error("wake flag rose without a received byte");
  a_wake_sticky: assert property (wake_flag_out && !(wb_ack_out && wb_we_in && wb_adr_in[7:2] == 6'h04 && wb_dat_in[0])
    |=> wake_flag_out)
    else $error("wake flag dropped without a clear");
endmodule : erdw_rx_properties

bind erdw_rx_top erdw_rx_properties i_props (.clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_dat_in, .wb_ack_out, .rx_valid_in, .mem_req_out, .mem_we_out, .mem_adr_out, .mem_ack_in, .buf_ptr_out,
  .buf_ptr_valid_out, .desc_done_out, .wake_flag_out);

`default_nettype wire

// ==== bench/erdw_mem_model.sv ====
// Word-wide descriptor memory on the engine port.
// Assumes requests are held until ack; the bench sets the latency.
`timescale 1ns/1ns
`default_nettype none

module erdw_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] adr_in,
  input  wire logic [31:0] dat_in,
  input  wire logic [3:0]  lat_in,
  output logic [31:0]      dat_out,
  output logic             ack_out
);
  logic [31:0] mem [256];
  logic [3:0]  wait_reg = 4'h0;

  initial dat_out = 32'h0;
  initial ack_out = 1'b0;
  // Plain always so the bench may preload words
  always @(posedge clk_in) begin
    if (req_in && !ack_out && wait_reg == lat_in) begin
      ack_out  <= 1'b1;
      wait_reg <= 4'h0;
      if (we_in)
        mem[adr_in[9:2]] <= dat_in;
      else
        dat_out <= mem[adr_in[9:2]];
    end else begin
      ack_out  <= 1'b0;
      // Stale data is inverted on each cycle without ack, so the last word reappears every other cycle
      dat_out  <= ~dat_out;
      wait_reg <= (req_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : erdw_mem_model

`default_nettype wire

// ==== bench/erdw_rx_top_tb.sv ====
// Self-checking bench for the rx descriptor writer and wake detector.
// Assumes the memory model on the engine port and Wishbone driven here.
`timescale 1ns/1ns
`default_nettype none
`include "erdw_defs.svh"

module erdw_rx_top_tb
  import erdw_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wb_cyc_in = 1'b0;
  logic        wb_stb_in = 1'b0;
  logic        wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0;
  logic        rx_valid_in = 1'b0;
  logic        rx_last_in = 1'b0;
  logic [7:0]  rx_data_in = 8'h00;
  logic        rx_crc_err_in = 1'b0;
  logic [3:0]  wb_sel_in = 4'hf;
  logic [3:0]  lat = 4'h0;
  logic [31:0] wb_dat_out, mem_adr_out, mem_dat_out, mem_dat_in, buf_ptr_out, rd;
  logic        wb_ack_out, mem_req_out, mem_we_out, mem_ack_in, buf_ptr_valid_out, desc_done_out, wake_flag_out;
  logic [7:0]  frm [$];
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;

  erdw_rx_top i_dut (.clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .rx_valid_in, .rx_data_in, .rx_last_in, .rx_crc_err_in,
    .mem_req_out, .mem_we_out, .mem_adr_out, .mem_dat_out, .mem_dat_in, .mem_ack_in, .buf_ptr_out,
    .buf_ptr_valid_out, .desc_done_out, .wake_flag_out);

  erdw_mem_model i_mem (.clk_in, .req_in(mem_req_out), .we_in(mem_we_out), .adr_in(mem_adr_out),
    .dat_in(mem_dat_out), .lat_in(lat), .dat_out(mem_dat_in), .ack_out(mem_ack_in));

  initial forever #20 clk_in = ~clk_in;

  // A hang ends the run as a mismatch
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input string what, input erdw_word_t exp, input erdw_word_t got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input erdw_word_t d);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge clk_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb

  task automatic send();
    foreach (frm[i]) begin
      @(posedge clk_in);
      rx_valid_in <= 1'b1;
      rx_data_in  <= frm[i];
      rx_last_in  <= (i == frm.size() - 1);
    end
    @(posedge clk_in);
    rx_valid_in <= 1'b0;
    rx_last_in  <= 1'b0;
  endtask : send

  function automatic erdw_word_t fmt(input logic [15:0] h0, input logic [15:0] h2, input logic s);
    return s ? {h0, h2} : {h2[7:0], h2[15:8], h0[7:0], h0[15:8]};
  endfunction : fmt

  // Tagged frame, priority 7, IPv4 protocol 0x11, 64 bytes
  task automatic desc_case(input logic [2:0] ctrl, input logic [9:0] base);
    int k;
    k = base >> 2;
    lat <= base[9:6];
    i_mem.mem[k] = fmt(16'h8000, 16'h0000, ctrl[0]);
    i_mem.mem[k + 1] = fmt(16'h1234, 16'h5678, ctrl[0]);
    i_mem.mem[k + 2] = 32'ha5a5_a5a5;
    i_mem.mem[k + 3] = 32'ha5a5_a5a5;
    wb(1'b1, `ERDW_REG_CTRL, {29'h0, ctrl});
    wb(1'b1, `ERDW_REG_RING_BASE, {22'h0, base});
    frm = {};
    repeat (64) frm.push_back(8'h00);
    frm[0] = 8'h02;
    frm[12] = 8'h81;
    frm[14] = 8'he0;
    frm[16] = 8'h08;
    frm[27] = 8'h11;
    // Error level only matters with the last byte
    rx_crc_err_in <= ctrl[0];
    send();
    rx_crc_err_in <= 1'b0;
    for (int i = 0; i < 200 && desc_done_out !== 1'b1; i++) @(posedge clk_in);
    chk("status word", fmt({13'h0100, ctrl[0], 2'b00}, 16'h0040, ctrl[0]), i_mem.mem[k]);
    chk("buffer pointer", 32'h1234_5678, buf_ptr_out);
    chk("priority word", ctrl[2] ? fmt(16'h0, 16'he004, ctrl[0]) : 32'ha5a5_a5a5, i_mem.mem[k + 2]);
    chk("header word", ctrl[2] ? fmt(16'h9011, 16'h0, ctrl[0]) : 32'ha5a5_a5a5, i_mem.mem[k + 3]);
    wb(1'b0, `ERDW_REG_CUR_DESC, 32'h0);
    chk("next descriptor", {22'h0, base} + (ctrl[2] ? 32'h20 : 32'h08), rd);
  endtask : desc_case

  // Sync run after stray bytes, then a number of station copies
  task automatic wake_case(input logic en, input int copies, input logic exp);
    frm = {8'h00, 8'hff, 8'h17};
    repeat (6) frm.push_back(8'hff);
    repeat (copies) for (int b = 1; b <= 6; b++) frm.push_back(8'(8'h11 * b));
    frm.push_back(8'h00);
    frm.push_back(8'h00);
    wb(1'b1, `ERDW_REG_CTRL, {30'h0, en, 1'b0});
    send();
    repeat (4) @(posedge clk_in);
    chk("wake flag", {31'h0, exp}, {31'h0, wake_flag_out});
    wb(1'b0, `ERDW_REG_STATUS, 32'h0);
    chk("status wake bit", {31'h0, exp}, {31'h0, rd[0]});
    wb(1'b1, `ERDW_REG_STATUS, 32'h1);
    repeat (30) @(posedge clk_in);
  endtask : wake_case

  initial begin
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 32'h0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, `ERDW_REG_CTRL, 32'h0);
    chk("control reset", 32'h0, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rd);
    desc_case(3'h0, 10'h000);
    desc_case(3'h1, 10'h040);
    desc_case(3'h4, 10'h080);
    desc_case(3'h5, 10'h100);
    wb(1'b0, `ERDW_REG_COUNTS, 32'h0);
    chk("completed count", 32'h4, {16'h0, rd[15:0]});
    wb_sel_in <= 4'hc;
    wb(1'b1, `ERDW_REG_STA_LO, 32'h4433_ffff);
    wb_sel_in <= 4'h3;
    wb(1'b1, `ERDW_REG_STA_LO, 32'hffff_2211);
    wb_sel_in <= 4'hf;
    wb(1'b0, `ERDW_REG_STA_LO, 32'h0);
    chk("station low lanes", 32'h4433_2211, rd);
    wb(1'b1, `ERDW_REG_STA_HI, 32'h0000_6655);
    wake_case(1'b1, 16, 1'b1);
    wake_case(1'b1, 6, 1'b0);
    wake_case(1'b1, 15, 1'b0);
    wake_case(1'b0, 16, 1'b0);
    results();
  end
endmodule : erdw_rx_top_tb

`default_nettype wire
